// ===== dv/idc_config_port_tb_top.sv
// self-checking bench: bus registers, decoded dividers, serial transfers
module idc_config_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import idc_pkg::*;
    logic        mclk     = 1'b0;
    logic        rst      = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0;
    logic        addr_sel = 1'b0;
    logic [1:0]  freq_config_select     = 2'h0;
    logic [31:0] prdata, rdv;
    logic        pready, pslverr, erv, scl, host_sda, sda_oe, en_a, en_b, ack;
    logic [9:0]  fb_ratio;
    logic [3:0]  pre_ratio;
    logic [1:0]  cp_range;
    logic [7:0]  ra, fa, rb, fbr, nib, rx, dv;
    logic [7:0]  fbs [3];
    logic [7:0]  nis [3];
    logic [7:0]  dat [4];
    int          num_checks  = 0;
    int          miscompares = 0;
    int          cyc         = 0;
    wire logic   sda_line = sda_oe ? 1'b0 : host_sda;
    idc_config_port DUT (
        .mclk_in(mclk), .reset_in(rst), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .scl_in(scl),
        .serial_data_pin_in(sda_line), .serial_data_pin_out(),
        .serial_data_pin_oe_out(sda_oe), .addr_sel_in(addr_sel),
        .freq_config_select_in(freq_config_select), .feedback_ratio_out(fb_ratio),
        .prescale_ratio_out(pre_ratio), .charge_pump_range_out(cp_range),
        .out_ratio_a_out(ra), .out_frac_div_a_out(fa), .out_ratio_b_out(rb),
        .out_frac_div_b_out(fbr), .bank_a_enable_out(en_a), .bank_b_enable_out(en_b));
    idc_i2c_host host (.mclk_in(mclk), .sda_line_in(sda_line), .scl_out(scl),
        .sda_out(host_sda));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one bus transfer: hold until ready is sampled, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input int n, input logic [7:0] v);
        apb(1'b1, 12'(4 * n), {24'h0, v});
    endtask
    task automatic i2c(input logic [7:0] tx, input logic ai);
        host.xfer_byte(tx, ai, rx, ack);
    endtask
    function automatic logic [9:0] fb_exp(input logic [7:0] c);
        return {1'b0, c, 1'b0};
    endfunction
    function automatic logic [7:0] out_exp(input logic [7:0] c, input logic byp);
        return byp ? 8'h02 : {1'b0, c[5:0], 1'b0};
    endfunction
    function automatic logic [1:0] cp_exp(input logic [7:0] c);
        int r;
        r = 2 * c;
        return (r <= 48) ? 2'h0 : (r <= 100) ? 2'h1 : (r <= 192) ? 2'h2 : 2'h3;
    endfunction
    // watchdog on a hung handshake
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(61143));
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        check(fb_ratio, 32'h064);
        check(ra, 32'h14);
        check({en_b, en_a}, 32'h0);
        // three sets with corner and random codes, fraction zero
        for (int s = 0; s < 3; s++) begin
            fbs[s] = (s == 0) ? 8'h04 : (s == 1) ? 8'hFF : 8'($urandom_range(255, 8));
            nis[s] = (s == 0) ? 8'h02 : (s == 1) ? 8'h3F : 8'($urandom_range(63, 4));
            wr(4 * s + FB_OFS, fbs[s]);
            wr(4 * s + PRE_OFS, {4'h0, cp_exp(fbs[s]), 2'h0});
            wr(4 * s + NINT_OFS, nis[s]);
            wr(4 * s + NFRAC_OFS, 8'h00);
        end
        for (int p = 0; p < 4; p++) begin
            wr(PRE_OFS, {4'h0, cp_exp(fbs[0]), 2'(p)});
            repeat (3) @(posedge mclk);
            check(pre_ratio, 32'(1 << p));
        end
        // pins pick the set, code three falls back to set zero
        for (int f = 0; f < 4; f++) begin
            freq_config_select <= 2'(f);
            repeat (5) @(posedge mclk);
            check(fb_ratio, fb_exp(fbs[f % 3]));
            check(cp_range, cp_exp(fbs[f % 3]));
            check(ra, out_exp(nis[f % 3], 1'b0));
            check(fa, 32'h0);
        end
        nib = 8'($urandom_range(63, 2));
        wr(BANK_B_BASE + NINT_OFS, nib);
        for (int m = 0; m < 16; m++) begin
            wr(MODE_BYTE, 8'(m));
            repeat (3) @(posedge mclk);
            check(ra, out_exp(nis[0], m[0] & m[1]));
            check(rb, out_exp(nib, m[2] & m[3]));
            check(fbr, 32'h0);
        end
        // software override and output enables
        for (int j = 0; j < 4; j++) begin
            wr(SEL_BYTE, {3'h0, 2'(j), 1'b1, 2'(j % 3)});
            repeat (4) @(posedge mclk);
            check({en_b, en_a}, 32'(j));
            check(fb_ratio, fb_exp(fbs[j % 3]));
        end
        wr(SEL_BYTE, 8'h00);
        // refused addresses
        foreach (dat[i]) begin
            apb(1'b0, (i == 0) ? 12'h001 : (i == 1) ? 12'h064 : 12'hFFC, 32'h0);
            check({31'h0, erv}, 32'h1);
            check(rdv, 32'h0);
        end
        // serial block write at the alternate address
        addr_sel <= 1'b1;
        repeat (4) @(posedge mclk);
        host.start();
        i2c(8'hDE, 1'b1);
        check(ack, 32'h0);
        i2c(8'h10, 1'b1);
        foreach (dat[i]) begin
            dat[i] = 8'($urandom);
            i2c(dat[i], 1'b1);
            check(ack, 32'h0);
        end
        host.stop();
        foreach (dat[i]) begin
            apb(1'b0, 12'(4 * (16 + i)), 32'h0);
            check(rdv, {24'h0, dat[i]});
        end
        // address with the other select bit is not acknowledged
        host.start();
        i2c(8'hDC, 1'b1);
        check(ack, 32'h1);
        host.stop();
        // pointer, repeated start, read until the controller declines
        host.start();
        i2c(8'hDE, 1'b1);
        i2c(8'h11, 1'b1);
        host.start();
        i2c(8'hDF, 1'b1);
        check(ack, 32'h0);
        for (int i = 1; i < 4; i++) begin
            i2c(8'hFF, 1'(i == 3));
            check(rx, dat[i]);
        end
        host.stop();
        // write ended after one byte leaves the next byte alone
        dv = ~dat[0];
        host.start();
        i2c(8'hDE, 1'b1);
        i2c(8'h10, 1'b1);
        i2c(dv, 1'b1);
        host.stop();
        apb(1'b0, 12'h040, 32'h0);
        check(rdv, {24'h0, dv});
        apb(1'b0, 12'h044, 32'h0);
        check(rdv, {24'h0, dat[1]});
        end_sim();
    end
endmodule

// ===== dv/idc_i2c_host.sv
// serial bus controller model driving the clock and open-drain data
module idc_i2c_host (
    input  wire logic mclk_in,
    input  wire logic sda_line_in,
    output logic      scl_out,
    output logic      sda_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus: both lines released high
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_out <= 1'b1;
        tick(3);
        scl_out <= 1'b1;
        tick(4);
        sda_out <= 1'b0;
        tick(3);
        scl_out <= 1'b0;
        tick(3);
    endtask
    // stop after a whole byte, then the bus stands still
    task automatic stop();
        sda_out <= 1'b0;
        tick(3);
        scl_out <= 1'b1;
        tick(4);
        sda_out <= 1'b1;
        tick(6);
    endtask
    // one bit: set while clock low, sampled mid high phase, 13 cycles
    task automatic bit_io(input logic b, output logic got);
        sda_out <= b;
        tick(4);
        scl_out <= 1'b1;
        tick(3);
        got = sda_line_in;
        tick(3);
        scl_out <= 1'b0;
        tick(3);
    endtask
    // one byte msb first, then the acknowledge slot
    task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                             output logic [7:0] rx, output logic ack_out);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], g);
            rx[i] = g;
        end
        bit_io(ack_in, ack_out);
    endtask
endmodule

// ===== dv/idc_port_checker.sv
// concurrent checks on the pins of the configuration port
module idc_port_checker (
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] prdata_out,
    input  wire logic        pready_out,
    input  wire logic        pslverr_out,
    input  wire logic        scl_in,
    input  wire logic        serial_data_pin_oe_out,
    input  wire logic [9:0]  feedback_ratio_out,
    input  wire logic [3:0]  prescale_ratio_out,
    input  wire logic [7:0]  out_ratio_a_out,
    input  wire logic [7:0]  out_ratio_b_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // bus answer after exactly one wait state, as a single pulse
    a_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("bus access not answered after one wait state");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready stood longer than one cycle");
    a_ready_cause: assert property ($rose(pready_out) |-> $past(psel_in && penable_in))
        else $error("ready without an access phase");
    // unaligned words are refused with zero data
    a_err_refused: assert property (psel_in && penable_in && !pready_out && paddr_in[1:0] != 2'h0
        |=> pslverr_out && prdata_out == 32'h0)
        else $error("unaligned access not refused");
    // decoded ratios keep their coding
    a_fb_twice: assert property (feedback_ratio_out[0] == 1'b0)
        else $error("feedback ratio is odd");
    a_fb_floor: assert property (feedback_ratio_out != 10'h0 |-> feedback_ratio_out >= 10'h008)
        else $error("feedback ratio below eight");
    a_pre_power: assert property ($onehot(prescale_ratio_out))
        else $error("prescale ratio not one of 1, 2, 4, 8");
    a_out_twice: assert property (out_ratio_a_out[0] == 1'b0 && out_ratio_b_out[0] == 1'b0)
        else $error("output ratio is odd");
    // data line only moves while the serial clock is low
    a_ack_scl_low: assert property ($changed(serial_data_pin_oe_out) |-> !scl_in)
        else $error("data line changed with clock high");
    a_quiet_reset: assert property ($fell(reset_in) |-> !serial_data_pin_oe_out [*3])
        else $error("data line pulled right after reset");
    c_refused: cover property (pslverr_out);
    c_ack: cover property ($rose(serial_data_pin_oe_out));
    c_bypass: cover property (out_ratio_a_out == 8'h02);
endmodule

bind idc_config_port idc_port_checker u_chk (
    .mclk_in(mclk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
    .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .scl_in(scl_in),
    .serial_data_pin_oe_out(serial_data_pin_oe_out),
    .feedback_ratio_out(feedback_ratio_out), .prescale_ratio_out(prescale_ratio_out),
    .out_ratio_a_out(out_ratio_a_out), .out_ratio_b_out(out_ratio_b_out)
);

// ===== hw/idc_cfg_mem.sv
// configuration byte store with two write ports and a registered read port
module idc_cfg_mem (
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    idc_mem_if.store    mem
);
    import idc_pkg::*;

    logic [7:0] bytes_r   [NUM_BYTES];
    logic [7:0] bytes_nxt [NUM_BYTES];
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;

    // power-up value of each byte
    function automatic logic [7:0] reset_byte(input int idx);
        if (idx < BANK_B_BASE + CFG_STRIDE && (idx % CFG_STRIDE) == FB_OFS) begin
            return RESET_FB;
        end
        if (idx < BANK_B_BASE + CFG_STRIDE && (idx % CFG_STRIDE) == NINT_OFS) begin
            return RESET_NINT;
        end
        return 8'h00;
    endfunction

    // serial writes win over bus writes to the same byte
    always_comb begin
        for (int i = 0; i < NUM_BYTES; i++) begin
            bytes_nxt[i] = bytes_r[i];
            if (mem.i2c_we && mem.i2c_addr == 8'(i)) begin
                bytes_nxt[i] = mem.i2c_wdata;
            end else if (mem.apb_we && mem.apb_addr == 8'(i)) begin
                bytes_nxt[i] = mem.apb_wdata;
            end
        end
        rd_nxt = (mem.rd_addr < 8'(NUM_BYTES)) ? bytes_r[mem.rd_addr[4:0]] : 8'h00;
    end

    always_ff @(posedge clk_in) begin
        for (int i = 0; i < NUM_BYTES; i++) begin
            bytes_r[i] <= rst_in ? reset_byte(i) : bytes_nxt[i];
        end
        rd_r <= rst_in ? 8'h00 : rd_nxt;
    end

    // flat view for the decoders and the bus
    always_comb begin
        for (int i = 0; i < NUM_BYTES; i++) begin
            mem.flat[i*8 +: 8] = bytes_r[i];
        end
    end
    assign mem.rd_data = rd_r;
endmodule

// ===== hw/idc_config_port.sv
// serial target, bus slave and divider decode for the clock generator settings
//
// The address map and the APB register port are this design's own decisions.
module idc_config_port (
    input  wire logic                        mclk_in,
    input  wire logic                        reset_in,
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [idc_pkg::APB_AW-1:0]  paddr_in,
    input  wire logic [31:0]                 pwdata_in,
    output logic      [31:0]                 prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    input  wire logic                        scl_in,
    input  wire logic                        serial_data_pin_in,
    output logic                             serial_data_pin_out,
    output logic                             serial_data_pin_oe_out,
    input  wire logic                        addr_sel_in,
    input  wire logic [1:0]                  freq_config_select_in,
    output logic      [9:0]                  feedback_ratio_out,
    output logic      [3:0]                  prescale_ratio_out,
    output logic      [1:0]                  charge_pump_range_out,
    output logic      [7:0]                  out_ratio_a_out,
    output logic      [7:0]                  out_frac_div_a_out,
    output logic      [7:0]                  out_ratio_b_out,
    output logic      [7:0]                  out_frac_div_b_out,
    output logic                             bank_a_enable_out,
    output logic                             bank_b_enable_out
);
    import idc_pkg::*;

    idc_mem_if mem ();

    idc_cfg_mem u_mem (
        .clk_in (mclk_in),
        .rst_in (reset_in),
        .mem    (mem)
    );

    // pick a byte out of the flat store
    function automatic logic [7:0] byte_at(input idc_flat_t f, input int idx);
        return f[idx*8 +: 8];
    endfunction

    // output divider ratio: twice the low six code bits, or two when int_m and byp are both set
    function automatic logic [7:0] out_ratio(input logic [7:0] nint, input logic int_m,
                                             input logic byp);
        if (int_m && byp) begin
            return BYPASS_RATIO;
        end
        return {1'b0, nint[5:0], 1'b0};
    endfunction

    // ---------------- pin synchronisers ----------------
    logic [4:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
    logic       scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;

    // two stages for every pin, then one delay for edge finding
    always_comb begin
        sync1_nxt = {freq_config_select_in, addr_sel_in, serial_data_pin_in, scl_in};
        sync2_nxt = sync1_r;
        scl_d_nxt = sync2_r[0];
        sda_d_nxt = sync2_r[1];
    end

    always_ff @(posedge mclk_in) begin
        sync1_r <= reset_in ? 5'h1F : sync1_nxt;
        sync2_r <= reset_in ? 5'h1F : sync2_nxt;
        scl_d_r <= reset_in ? 1'b1 : scl_d_nxt;
        sda_d_r <= reset_in ? 1'b1 : sda_d_nxt;
    end

    logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
    assign scl_s    = sync2_r[0];
    assign sda_s    = sync2_r[1];
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ---------------- serial target ----------------
    idc_state_e state_r, state_nxt;
    logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic       rd_mode_r, rd_mode_nxt, nack_r, nack_nxt, low_r, low_nxt;
    logic       wr_en;

    // bit engine: sample on scl rise, drive on scl fall
    always_comb begin
        state_nxt   = state_r;
        shift_nxt   = shift_r;
        ptr_nxt     = ptr_r;
        bit_nxt     = bit_r;
        rd_mode_nxt = rd_mode_r;
        nack_nxt    = nack_r;
        low_nxt     = low_r;
        wr_en       = 1'b0;
        if (stop_ev) begin
            state_nxt = IDC_IDLE;
            low_nxt   = 1'b0;
        end else if (start_ev) begin
            state_nxt = IDC_ADDR;
            bit_nxt   = 4'h0;
            low_nxt   = 1'b0;
        end else if (scl_rise) begin
            case (state_r)
                IDC_ADDR, IDC_PTR, IDC_WDAT: begin
                    shift_nxt = {shift_r[6:0], sda_s};
                    bit_nxt   = bit_r + 4'h1;
                end
                IDC_RDAT: begin
                    bit_nxt = bit_r + 4'h1;
                end
                IDC_RACK: begin
                    nack_nxt = sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_r)
                IDC_ADDR: begin
                    if (bit_r == 4'h8) begin
                        if (shift_r[7:1] == {DEV_ADDR_HI, sync2_r[2]}) begin
                            rd_mode_nxt = shift_r[0];
                            low_nxt     = 1'b1;
                            state_nxt   = IDC_AACK;
                        end else begin
                            state_nxt = IDC_IDLE;
                        end
                    end
                end
                IDC_PTR: begin
                    if (bit_r == 4'h8) begin
                        ptr_nxt   = shift_r;
                        low_nxt   = 1'b1;
                        state_nxt = IDC_PACK;
                    end
                end
                IDC_WDAT: begin
                    if (bit_r == 4'h8) begin
                        wr_en     = 1'b1;
                        low_nxt   = 1'b1;
                        state_nxt = IDC_WACK;
                    end
                end
                IDC_AACK, IDC_RACK: begin
                    bit_nxt = 4'h0;
                    if (!rd_mode_r) begin
                        low_nxt   = 1'b0;
                        state_nxt = IDC_PTR;
                    end else if (state_r == IDC_RACK && nack_r) begin
                        low_nxt   = 1'b0;
                        state_nxt = IDC_IDLE;
                    end else begin
                        shift_nxt = mem.rd_data;
                        low_nxt   = ~mem.rd_data[7];
                        ptr_nxt   = ptr_r + 8'h01;
                        state_nxt = IDC_RDAT;
                    end
                end
                IDC_PACK, IDC_WACK: begin
                    if (state_r == IDC_WACK) begin
                        ptr_nxt = ptr_r + 8'h01;
                    end
                    bit_nxt   = 4'h0;
                    low_nxt   = 1'b0;
                    state_nxt = IDC_WDAT;
                end
                IDC_RDAT: begin
                    if (bit_r == 4'h8) begin
                        low_nxt   = 1'b0;
                        state_nxt = IDC_RACK;
                    end else begin
                        shift_nxt = {shift_r[6:0], 1'b0};
                        low_nxt   = ~shift_r[6];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        state_r   <= reset_in ? IDC_IDLE : state_nxt;
        shift_r   <= reset_in ? 8'h00 : shift_nxt;
        ptr_r     <= reset_in ? 8'h00 : ptr_nxt;
        bit_r     <= reset_in ? 4'h0 : bit_nxt;
        rd_mode_r <= reset_in ? 1'b0 : rd_mode_nxt;
        nack_r    <= reset_in ? 1'b0 : nack_nxt;
        low_r     <= reset_in ? 1'b0 : low_nxt;
    end

    // open drain: only ever pull low
    assign serial_data_pin_out    = 1'b0;
    assign serial_data_pin_oe_out = low_r;
    assign mem.i2c_we    = wr_en;
    assign mem.i2c_addr  = ptr_r;
    assign mem.i2c_wdata = shift_r;
    assign mem.rd_addr   = ptr_r;

    // ---------------- apb slave ----------------
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic        byte_hit, stat_hit;
    logic [7:0]  apb_idx;
    logic [1:0]  sel_r, sel_nxt, sw_sel;

    assign apb_idx  = paddr_in[9:2];
    assign byte_hit = paddr_in[1:0] == 2'b00 && paddr_in[11:10] == 2'b00
                      && apb_idx < 8'(NUM_BYTES);
    assign stat_hit = paddr_in == STATUS_ADDR;

    // answer one cycle into the access phase; the write lands on the next edge, where ready is sampled
    always_comb begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        pready_nxt  = 1'b0;
        if (psel_in && penable_in && !pready_r) begin
            pready_nxt  = 1'b1;
            pslverr_nxt = ~(byte_hit | stat_hit);
            prdata_nxt  = 32'h0000_0000;
            if (!pwrite_in && byte_hit) begin
                prdata_nxt = {24'h00_0000, byte_at(mem.flat, int'(apb_idx[4:0]))};
            end else if (!pwrite_in && stat_hit) begin
                prdata_nxt = {16'h0000, ptr_r, 1'b0, sel_r, rd_mode_r, state_r};
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        prdata_r  <= reset_in ? 32'h0000_0000 : prdata_nxt;
        pready_r  <= reset_in ? 1'b0 : pready_nxt;
        pslverr_r <= reset_in ? 1'b0 : pslverr_nxt;
    end

    assign mem.apb_we    = psel_in & penable_in & pready_r & pwrite_in & byte_hit;
    assign mem.apb_addr  = apb_idx;
    assign mem.apb_wdata = pwdata_in[7:0];
    assign prdata_out    = prdata_r;
    assign pready_out    = pready_r;
    assign pslverr_out   = pslverr_r;

    // ---------------- configuration decode ----------------
    logic [7:0] mode_b, ctl_b, fb_b, pre_b;
    logic [9:0] fb_nxt;
    logic [3:0] pre_nxt;
    logic [1:0] cp_nxt;
    logic [7:0] ra_nxt, fa_nxt, rb_nxt, fb2_nxt;
    logic       ea_nxt, eb_nxt;
    logic [9:0] fb_q;
    logic [3:0] pre_q;
    logic [1:0] cp_q;
    logic [7:0] ra_q, fa_q, rb_q, fb2_q;
    logic       ea_q, eb_q;

    assign mode_b = byte_at(mem.flat, MODE_BYTE);
    assign ctl_b  = byte_at(mem.flat, SEL_BYTE);
    assign sw_sel = ctl_b[SW_SEL_LSB +: 2];

    // select pins or software override choose the active set; code 3 falls to set 0
    always_comb begin
        sel_nxt = ctl_b[SW_OVR_BIT] ? sw_sel : sync2_r[4:3];
        if (sel_nxt == 2'b11) begin
            sel_nxt = 2'b00;
        end
        fb_b    = byte_at(mem.flat, int'(sel_r) * CFG_STRIDE + FB_OFS);
        pre_b   = byte_at(mem.flat, int'(sel_r) * CFG_STRIDE + PRE_OFS);
        fb_nxt  = {1'b0, fb_b, 1'b0};
        pre_nxt = 4'h1 << pre_b[PRE_LSB +: 2];
        cp_nxt  = pre_b[CP_LSB +: 2];
        ra_nxt  = out_ratio(byte_at(mem.flat, int'(sel_r) * CFG_STRIDE + NINT_OFS),
                            mode_b[A_INT_BIT], mode_b[A_BYP_BIT]);
        fa_nxt  = byte_at(mem.flat, int'(sel_r) * CFG_STRIDE + NFRAC_OFS);
        rb_nxt  = out_ratio(byte_at(mem.flat, BANK_B_BASE + NINT_OFS),
                            mode_b[B_INT_BIT], mode_b[B_BYP_BIT]);
        fb2_nxt = byte_at(mem.flat, BANK_B_BASE + NFRAC_OFS);
        ea_nxt  = ctl_b[OE_A_BIT];
        eb_nxt  = ctl_b[OE_B_BIT];
    end

    always_ff @(posedge mclk_in) begin
        sel_r <= reset_in ? 2'b00 : sel_nxt;
        fb_q  <= reset_in ? 10'h000 : fb_nxt;
        pre_q <= reset_in ? 4'h1 : pre_nxt;
        cp_q  <= reset_in ? 2'b00 : cp_nxt;
        ra_q  <= reset_in ? 8'h00 : ra_nxt;
        fa_q  <= reset_in ? 8'h00 : fa_nxt;
        rb_q  <= reset_in ? 8'h00 : rb_nxt;
        fb2_q <= reset_in ? 8'h00 : fb2_nxt;
        ea_q  <= reset_in ? 1'b0 : ea_nxt;
        eb_q  <= reset_in ? 1'b0 : eb_nxt;
    end

    assign feedback_ratio_out    = fb_q;
    assign prescale_ratio_out    = pre_q;
    assign charge_pump_range_out = cp_q;
    assign out_ratio_a_out       = ra_q;
    assign out_frac_div_a_out    = fa_q;
    assign out_ratio_b_out       = rb_q;
    assign out_frac_div_b_out    = fb2_q;
    assign bank_a_enable_out     = ea_q;
    assign bank_b_enable_out     = eb_q;
endmodule

// ===== hw/idc_mem_if.sv
// carrier between the port logic and the configuration byte store
interface idc_mem_if;
    import idc_pkg::*;
    logic            i2c_we;
    logic [7:0]      i2c_addr;
    logic [7:0]      i2c_wdata;
    logic            apb_we;
    logic [7:0]      apb_addr;
    logic [7:0]      apb_wdata;
    logic [7:0]      rd_addr;
    logic [7:0]      rd_data;
    idc_flat_t       flat;
    modport store (input i2c_we, i2c_addr, i2c_wdata, apb_we, apb_addr, apb_wdata,
                   rd_addr, output rd_data, flat);
    modport user  (output i2c_we, i2c_addr, i2c_wdata, apb_we, apb_addr, apb_wdata,
                   rd_addr, input rd_data, flat);
endinterface

// ===== hw/idc_pkg.sv
// constants, field layout and state codes of the divider configuration port
package idc_pkg;
    localparam int          NUM_BYTES    = 24;
    localparam int          APB_AW       = 12;
    localparam logic [5:0]  DEV_ADDR_HI  = 6'h37;      // upper six bits of the target address
    localparam logic [7:0]  RESET_FB     = 8'h32;      // feedback code 50, ratio 100
    localparam logic [7:0]  RESET_NINT   = 8'h0A;      // output code 10, ratio 20
    // byte layout of one configuration
    localparam int          CFG_STRIDE   = 4;
    localparam int          FB_OFS       = 0;
    localparam int          PRE_OFS      = 1;
    localparam int          NINT_OFS     = 2;
    localparam int          NFRAC_OFS    = 3;
    localparam int          BANK_B_BASE  = 12;
    localparam int          MODE_BYTE    = 20;
    localparam int          SEL_BYTE     = 21;
    // bit positions
    localparam int          PRE_LSB      = 0;
    localparam int          CP_LSB       = 2;
    localparam int          A_INT_BIT    = 0;
    localparam int          A_BYP_BIT    = 1;
    localparam int          B_INT_BIT    = 2;
    localparam int          B_BYP_BIT    = 3;
    localparam int          SW_SEL_LSB   = 0;
    localparam int          SW_OVR_BIT   = 2;
    localparam int          OE_A_BIT     = 3;
    localparam int          OE_B_BIT     = 4;
    // apb map: byte n of the register file sits at 4*n
    localparam logic [11:0] STATUS_ADDR  = 12'h060;
    localparam logic [7:0]  BYPASS_RATIO = 8'h02;
    typedef enum logic [3:0] {
        IDC_IDLE  = 4'b0000,
        IDC_ADDR  = 4'b0001,
        IDC_AACK  = 4'b0010,
        IDC_PTR   = 4'b0011,
        IDC_PACK  = 4'b0100,
        IDC_WDAT  = 4'b0101,
        IDC_WACK  = 4'b0110,
        IDC_RDAT  = 4'b0111,
        IDC_RACK  = 4'b1000
    } idc_state_e;
    typedef logic [NUM_BYTES*8-1:0] idc_flat_t;
endpackage
